// file: verilog/rit_pkg.sv
// register map, field layout, reset values and generator constants for the
// receive-input test block; assumes 32-bit APB and one 10 MHz clock
package rit_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_NOISE_MASK = 8'h04;
    localparam logic [7:0] OFF_CONST      = 8'h08;
    localparam logic [7:0] OFF_CNT_IVAL   = 8'h0C;
    localparam logic [7:0] OFF_CNT_CFG    = 8'h10;
    localparam logic [7:0] OFF_DLY_OFF    = 8'h14;
    localparam logic [7:0] OFF_DLY_SSEL   = 8'h18;
    localparam logic [7:0] OFF_TST_CFG    = 8'h1C;
    localparam logic [7:0] OFF_STATUS     = 8'h20;
    localparam logic [7:0] OFF_LFSR_A     = 8'h24;
    // ************************************************************
    // control register bits
    // ************************************************************
    localparam int CTRL_SELF_TEST  = 0;
    localparam int CTRL_NOISE_ADD  = 1;
    localparam int CTRL_CONST_ENA  = 2;
    localparam int CTRL_BYPASS     = 3;
    localparam int CTRL_RATE_LSB   = 4;
    localparam int CTRL_TST_ON     = 6;
    localparam int CTRL_CLK_POL    = 7;
    localparam int CTRL_PROBE_RSV  = 8;
    localparam int CTRL_SOFT_SYNC  = 9;
    // ************************************************************
    // other field positions
    // ************************************************************
    localparam int CCFG_WIDTH_LSB  = 0;
    localparam int CCFG_SSEL_LSB   = 8;
    localparam int DOFF_STRIDE     = 8;
    localparam int DSSEL_STRIDE    = 4;
    localparam int TCFG_SRC_LSB    = 0;
    localparam int TCFG_DDCSEL_LSB = 4;
    localparam int TCFG_RATE_LSB   = 10;
    localparam int TCFG_DDLY_LSB   = 15;
    localparam int TCFG_SSEL_LSB   = 19;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [15:0] RST_MASK  = 16'h0000;
    localparam logic [17:0] RST_CONST = 18'h0_0000;
    localparam logic [31:0] RST_IVAL  = 32'h0000_0000;
    // ************************************************************
    // generators and test bus
    // ************************************************************
    localparam int LFSR_W  = 23;
    localparam int SMP_W   = 18;
    localparam int TB_W    = 36;
    localparam int DDC_N   = 8;
    localparam int SRC_RXI = 8;
    localparam logic [22:0] SEED_A = 23'h40_0010;
    localparam logic [22:0] SEED_B = 23'h26_E6CE;
    localparam logic [22:0] SEED_C = 23'h6E_A298;
    localparam logic [22:0] SEED_D = 23'h0B_1EB7;
    localparam logic [22:0] LFSR_TAPS = 23'h42_0000;
    localparam int OUT_XOR_SPAN = 7;
endpackage : rit_pkg

// file: verilog/rit_top.sv
// receive-input test logic: pseudorandom/constant sources, noise add,
// sync counter, four sample delay lines and the test output bus.
// assumes APB master on clock_i and sample inputs synchronous to clock_i.
`timescale 1ns/1ps
module rit_top (
    input  wire logic                      clock_i,
    input  wire logic                      rstn_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire logic                      adc_valid_i,
    input  wire logic [15:0]               rxin_a_i,
    input  wire logic [15:0]               rxin_b_i,
    input  wire logic [15:0]               rxin_c_i,
    input  wire logic [15:0]               rxin_d_i,
    output logic      [15:0]               rxin_c_o,
    output logic      [15:0]               rxin_d_o,
    output logic                           rxin_cd_oe_n_o,
    input  wire logic [3:0]                sync_i,
    input  wire logic [rit_pkg::DDC_N*rit_pkg::TB_W-1:0] ddc_tst_data_i,
    output logic      [5:0]                ddc_tst_sel_o,
    output logic      [rit_pkg::SMP_W-1:0] rx_data_a_o,
    output logic      [rit_pkg::SMP_W-1:0] rx_data_b_o,
    output logic      [rit_pkg::SMP_W-1:0] rx_data_c_o,
    output logic      [rit_pkg::SMP_W-1:0] rx_data_d_o,
    output logic                           rx_valid_o,
    output logic      [rit_pkg::SMP_W-1:0] dly_data_a_o,
    output logic      [rit_pkg::SMP_W-1:0] dly_data_b_o,
    output logic      [rit_pkg::SMP_W-1:0] dly_data_c_o,
    output logic      [rit_pkg::SMP_W-1:0] dly_data_d_o,
    output logic                           dly_valid_o,
    output logic                           cnt_pulse_o,
    output logic      [3:0]                tst_hi_o,
    output logic                           tst_clk_o,
    output logic                           probe_reserved_bit_o
);
    import rit_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0]            ctrl;
        logic [15:0]            noise_power_mask;
        logic [17:0]            cval;
        logic [31:0]            ival;
        logic [7:0]             cwidth;
        logic [2:0]             cssel;
        logic [3:0][5:0]        off_pend;
        logic [3:0][5:0]        off_work;
        logic [3:0][2:0]        dssel;
        logic [21:0]            tcfg;
        logic                   soft_sync;
        logic [2:0]             div;
        logic                   cnt_run;
        logic [31:0]            cnt;
        logic [7:0]             pw;
        logic                   pulse;
        logic                   cnt_evt;
        logic [3:0][LFSR_W-1:0] lfsr;
        logic [3:0][SMP_W-1:0]  strm;
        logic                   sval;
        logic [5:0]             wp;
        logic [3:0][SMP_W-1:0]  dly;
        logic                   dval;
        logic [4:0]             tc;
        logic [3:0]             ddly;
        logic                   ddly_act;
        logic [TB_W-1:0]        tbus;
        logic                   tclk;
        logic                   oe_n;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } rit_state_t;

    rit_state_t           s_reg;
    rit_state_t           s_next;
    logic [SMP_W-1:0]     mem [4][64];
    logic [3:0][SMP_W-1:0] mem_rd;

    localparam logic [3:0][LFSR_W-1:0] SEEDS = {SEED_D, SEED_C, SEED_B,
                                                 SEED_A};

    // ************************************************************
    // delay line memories
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dly
            always_ff @(posedge clock_i) begin
                if (s_reg.sval) begin
                    mem[g][s_reg.wp] <= s_reg.strm[g];
                end
            end
            // pointer difference grows the delay one sample per step
            assign mem_rd[g] = mem[g][6'(s_reg.wp - s_reg.off_work[g])];
        end
    endgenerate

    function automatic logic sync_pick(input logic [2:0] sel,
                                       input logic [7:0] vec);
        sync_pick = vec[sel];
    endfunction : sync_pick

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [7:0]        svec;
        logic              smp;
        logic              run_lfsr;
        logic              acc;
        logic [15:0]       word;
        logic [15:0]       nz;
        logic [15:0]       rx;
        logic [SMP_W-1:0]  sum;
        logic [2:0]        nmask;
        logic [4:0]        rate;
        logic [3:0]        src;
        logic [TB_W-1:0]   tsrc;
        logic [31:0]       rd;
        logic              hit;
        s_next   = s_reg;
        svec     = {1'b1, s_reg.soft_sync, s_reg.cnt_evt, sync_i, 1'b0};
        run_lfsr = s_reg.ctrl[CTRL_SELF_TEST] | s_reg.ctrl[CTRL_NOISE_ADD];
        word     = '0;
        nz       = '0;
        rx       = '0;
        sum      = '0;
        tsrc     = '0;
        rd       = '0;
        hit      = 1'b1;
        smp      = 1'b0;
        acc      = 1'b0;
        nmask    = '0;
        rate     = s_reg.tcfg[TCFG_RATE_LSB +: 5];
        src      = s_reg.tcfg[TCFG_SRC_LSB +: 4];
        s_next.soft_sync = 1'b0;

        // sample strobe: bypass runs on the divided clock, else ADC valid
        nmask = 3'((4'h1 << s_reg.ctrl[CTRL_RATE_LSB +: 2]) - 4'h1);
        s_next.div = 3'(s_reg.div + 3'h1) & nmask;
        if (s_reg.ctrl[CTRL_BYPASS]) begin
            smp = (s_reg.div == 3'h0);
        end else begin
            smp = adc_valid_i;
        end

        // general-purpose counter
        s_next.cnt_evt = 1'b0;
        if (sync_pick(s_reg.cssel, svec)) begin
            s_next.cnt_run = 1'b1;
            s_next.cnt     = s_reg.ival;
        end else if (s_reg.cnt_run) begin
            if (s_reg.cnt == 32'h0000_0000) begin
                s_next.cnt     = s_reg.ival;
                s_next.cnt_evt = 1'b1;
                s_next.pulse   = 1'b1;
                s_next.pw      = s_reg.cwidth;
            end else begin
                s_next.cnt = s_reg.cnt - 32'h0000_0001;
            end
        end
        if (!s_next.cnt_evt && s_reg.pulse) begin
            if (s_reg.pw == 8'h00) begin
                s_next.pulse = 1'b0;
            end else begin
                s_next.pw = s_reg.pw - 8'h01;
            end
        end

        // generators and input stream selection
        s_next.sval = smp;
        for (int c = 0; c < 4; c++) begin
            if (s_reg.cnt_evt) begin
                s_next.lfsr[c] = SEEDS[c];
            end else if (smp && run_lfsr) begin
                // galois step, taps fixed in hardware
                s_next.lfsr[c] = (s_reg.lfsr[c] >> 1) ^
                    (s_reg.lfsr[c][0] ? LFSR_TAPS : '0);
            end
            for (int b = 0; b < 16; b++) begin
                word[b] = s_reg.lfsr[c][b] ^
                          s_reg.lfsr[c][b + OUT_XOR_SPAN];
            end
            case (c)
                0:       rx = rxin_a_i;
                1:       rx = rxin_b_i;
                2:       rx = s_reg.ctrl[CTRL_TST_ON] ? 16'h0000 : rxin_c_i;
                default: rx = s_reg.ctrl[CTRL_TST_ON] ? 16'h0000 : rxin_d_i;
            endcase
            nz = word & s_reg.noise_power_mask;
            if (smp) begin
                if (s_reg.ctrl[CTRL_CONST_ENA]) begin
                    s_next.strm[c] = s_reg.cval;
                end else if (s_reg.ctrl[CTRL_SELF_TEST]) begin
                    s_next.strm[c] = {{2{word[15]}}, word};
                end else if (s_reg.ctrl[CTRL_NOISE_ADD]) begin
                    sum = 18'({{2{rx[15]}}, rx} + {{2{nz[15]}}, nz});
                    s_next.strm[c] = sum;
                end else begin
                    s_next.strm[c] = {{2{rx[15]}}, rx};
                end
            end
            if (sync_pick(s_reg.dssel[c], svec)) begin
                s_next.off_work[c] = s_reg.off_pend[c];
            end
            if (s_reg.sval) begin
                s_next.dly[c] = (s_reg.off_work[c] == 6'h00) ?
                                s_reg.strm[c] : mem_rd[c];
            end
        end
        s_next.dval = s_reg.sval;
        if (s_reg.sval) begin
            s_next.wp = 6'(s_reg.wp + 6'h01);
        end

        // test bus source, decimator and clock
        if (src < 4'(SRC_RXI)) begin
            tsrc = ddc_tst_data_i[32'(src) * TB_W +: TB_W];
        end else if (src == 4'(SRC_RXI)) begin
            tsrc = {s_reg.strm[1], s_reg.strm[0]};
        end
        if (sync_pick(s_reg.tcfg[TCFG_SSEL_LSB +: 3], svec)) begin
            s_next.ddly_act = 1'b1;
            s_next.ddly     = s_reg.tcfg[TCFG_DDLY_LSB +: 4];
        end else if (s_reg.ddly_act) begin
            if (s_reg.ddly == 4'h0) begin
                s_next.ddly_act = 1'b0;
                s_next.tc       = 5'h00;
            end else begin
                s_next.ddly = s_reg.ddly - 4'h1;
            end
        end
        if (!(s_reg.ddly_act && s_reg.ddly == 4'h0)) begin
            s_next.tc = (s_reg.tc >= rate) ? 5'h00 : 5'(s_reg.tc + 5'h01);
        end
        if (s_next.tc == 5'h00) begin
            s_next.tbus = tsrc;
        end
        // data changes at count 0, clock edge sits half a period later
        if (rate == 5'h00) begin
            s_next.tclk = 1'b0;
        end else begin
            s_next.tclk = (s_next.tc >= 5'(({1'b0, rate} + 6'h01) >> 1)) ^
                          s_reg.ctrl[CTRL_CLK_POL];
        end

        // ************************************************************
        // APB slave: one wait state, answer on second access cycle
        // ************************************************************
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;
        acc = psel_i & penable_i & ~s_reg.pready;
        if (paddr_i == OFF_CTRL) begin
            rd = s_reg.ctrl & ~(32'h1 << CTRL_SOFT_SYNC);
        end else if (paddr_i == OFF_NOISE_MASK) begin
            rd = {16'h0000, s_reg.noise_power_mask};
        end else if (paddr_i == OFF_CONST) begin
            rd = {14'h0000, s_reg.cval};
        end else if (paddr_i == OFF_CNT_IVAL) begin
            rd = s_reg.ival;
        end else if (paddr_i == OFF_CNT_CFG) begin
            rd = {21'h00_0000, s_reg.cssel, s_reg.cwidth};
        end else if (paddr_i == OFF_DLY_OFF) begin
            for (int c = 0; c < 4; c++) begin
                rd[c * DOFF_STRIDE +: 6] = s_reg.off_pend[c];
            end
        end else if (paddr_i == OFF_DLY_SSEL) begin
            for (int c = 0; c < 4; c++) begin
                rd[c * DSSEL_STRIDE +: 3] = s_reg.dssel[c];
            end
        end else if (paddr_i == OFF_TST_CFG) begin
            rd = {10'h000, s_reg.tcfg};
        end else if (paddr_i == OFF_STATUS) begin
            for (int c = 0; c < 4; c++) begin
                rd[c * DOFF_STRIDE +: 6] = s_reg.off_work[c];
            end
            rd[6]  = s_reg.pulse;
            rd[7]  = s_reg.cnt_run;
        end else if (paddr_i == OFF_LFSR_A) begin
            rd = {9'h000, s_reg.lfsr[0]};
        end else begin
            hit = 1'b0;
        end
        if (acc) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = ~hit;
            s_next.prdata  = pwrite_i ? 32'h0000_0000 : rd;
            if (pwrite_i && hit) begin
                if (paddr_i == OFF_CTRL) begin
                    s_next.ctrl = {22'h00_0000, pwdata_i[9:0]};
                    s_next.ctrl[CTRL_SOFT_SYNC] = 1'b0;
                    s_next.soft_sync = pwdata_i[CTRL_SOFT_SYNC];
                end else if (paddr_i == OFF_NOISE_MASK) begin
                    s_next.noise_power_mask = pwdata_i[15:0];
                end else if (paddr_i == OFF_CONST) begin
                    s_next.cval = pwdata_i[17:0];
                end else if (paddr_i == OFF_CNT_IVAL) begin
                    s_next.ival = pwdata_i;
                end else if (paddr_i == OFF_CNT_CFG) begin
                    s_next.cwidth = pwdata_i[CCFG_WIDTH_LSB +: 8];
                    s_next.cssel  = pwdata_i[CCFG_SSEL_LSB +: 3];
                end else if (paddr_i == OFF_DLY_OFF) begin
                    for (int c = 0; c < 4; c++) begin
                        // taken any time, used only after sync
                        s_next.off_pend[c] =
                            pwdata_i[c * DOFF_STRIDE +: 6];
                    end
                end else if (paddr_i == OFF_DLY_SSEL) begin
                    for (int c = 0; c < 4; c++) begin
                        s_next.dssel[c] = pwdata_i[c * DSSEL_STRIDE +: 3];
                    end
                end else if (paddr_i == OFF_TST_CFG) begin
                    s_next.tcfg = pwdata_i[21:0];
                end
            end
        end
        // pin direction kept in its own flop so the enable is registered
        s_next.oe_n = ~s_next.ctrl[CTRL_TST_ON];
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg                  <= '0;
            s_reg.ctrl             <= RST_CTRL;
            s_reg.noise_power_mask <= RST_MASK;
            s_reg.cval             <= RST_CONST;
            s_reg.ival             <= RST_IVAL;
            s_reg.lfsr             <= {SEED_D, SEED_C, SEED_B, SEED_A};
            s_reg.oe_n             <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata_o             = s_reg.prdata;
    assign pready_o             = s_reg.pready;
    assign pslverr_o            = s_reg.pslverr;
    assign rx_data_a_o          = s_reg.strm[0];
    assign rx_data_b_o          = s_reg.strm[1];
    assign rx_data_c_o          = s_reg.strm[2];
    assign rx_data_d_o          = s_reg.strm[3];
    assign rx_valid_o           = s_reg.sval;
    assign dly_data_a_o         = s_reg.dly[0];
    assign dly_data_b_o         = s_reg.dly[1];
    assign dly_data_c_o         = s_reg.dly[2];
    assign dly_data_d_o         = s_reg.dly[3];
    assign dly_valid_o          = s_reg.dval;
    assign cnt_pulse_o          = s_reg.pulse;
    assign rxin_c_o             = s_reg.tbus[15:0];
    assign rxin_d_o             = s_reg.tbus[31:16];
    assign tst_hi_o             = s_reg.tbus[35:32];
    assign rxin_cd_oe_n_o       = s_reg.oe_n;
    assign tst_clk_o            = s_reg.tclk;
    assign ddc_tst_sel_o        = s_reg.tcfg[TCFG_DDCSEL_LSB +: 6];
    assign probe_reserved_bit_o = s_reg.ctrl[CTRL_PROBE_RSV];
endmodule : rit_top

// file: dv/rit_asserts.sv
// port checker for rit_top: apb answer, streams, test bus enable
// assumes bind into rit_top; ctrl is mirrored from apb writes
`timescale 1ns/1ps
module rit_asserts import rit_pkg::*; (
    input logic                      clock_i,
    input logic                      rstn_i,
    input logic                      psel_i,
    input logic                      penable_i,
    input logic                      pwrite_i,
    input logic [7:0]                paddr_i,
    input logic [31:0]               pwdata_i,
    input logic                      pready_o,
    input logic                      pslverr_o,
    input logic                      rx_valid_o,
    input logic                      dly_valid_o,
    input logic                      rxin_cd_oe_n_o,
    input logic [5:0]                ddc_tst_sel_o,
    input logic [rit_pkg::SMP_W-1:0] rx_data_a_o,
    input logic [rit_pkg::SMP_W-1:0] rx_data_b_o,
    input logic [rit_pkg::SMP_W-1:0] rx_data_c_o,
    input logic [rit_pkg::SMP_W-1:0] rx_data_d_o
);
    import rit_pkg::*;
    logic       taken;
    logic       tcfg_wr;
    logic       div8_on;
    logic [9:0] ctl_reg;
    logic [3:0] gap_reg;
    assign taken = psel_i && penable_i && !pready_o;
    assign tcfg_wr = taken && pwrite_i && paddr_i == OFF_TST_CFG;
    assign div8_on = ctl_reg[3] && ctl_reg[5:4] == 2'd3;
    // gap_reg: cycles since the last stream strobe, saturating
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_reg <= '0;
            gap_reg <= '0;
        end else begin
            if (taken && pwrite_i && paddr_i == OFF_CTRL) begin
                ctl_reg <= pwdata_i[9:0];
            end
            if (rx_valid_o) begin
                gap_reg <= '0;
            end else if (gap_reg != 4'hF) begin
                gap_reg <= gap_reg + 4'h1;
            end
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    sequence s_answer; pready_o ##1 !pready_o; endsequence
    // nine held samples in div-8 mode also cover the previous strobe,
    // so a mode change in the middle never trips the spacing check
    sequence s_div8; (div8_on && $stable(ctl_reg))[*8]
        ##1 (div8_on && $stable(ctl_reg) && rx_valid_o); endsequence
    a_ready_once: assert property (taken |=> s_answer)
        else $error("apb answer not a single pulse");
    a_err_unmapped: assert property (taken && (paddr_i > OFF_LFSR_A ||
        paddr_i[1:0] != 2'b00) |=> pslverr_o) else $error("no error");
    a_err_mapped: assert property (taken && paddr_i == OFF_CTRL |=> !pslverr_o)
        else $error("error on mapped address");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_dly_after: assert property (rx_valid_o |=> dly_valid_o)
        else $error("delay valid missing");
    a_oe_follow: assert property ($stable(ctl_reg)[*3] |->
        rxin_cd_oe_n_o == !ctl_reg[6]) else $error("pin direction wrong");
    a_const_all: assert property ((ctl_reg[2] && $stable(ctl_reg))[*3] ##0
        rx_valid_o |-> rx_data_a_o == rx_data_b_o && rx_data_b_o ==
        rx_data_c_o && rx_data_c_o == rx_data_d_o) else $error("const differs");
    a_bypass_div: assert property (s_div8 |-> gap_reg == 4'h7)
        else $error("bypass strobe spacing wrong");
    a_sel_write: assert property ($changed(ddc_tst_sel_o) |->
        $past(tcfg_wr) || $past(tcfg_wr, 2)) else $error("select moved alone");
endmodule : rit_asserts
bind rit_top rit_asserts u_chk (.*);

// file: dv/rit_ddc_model.sv
// far-side model: eight downconverter test words
// assumes sel_i from rit_top; word = block number, select, running count
`timescale 1ns/1ps
module rit_ddc_model import rit_pkg::*; (
    input  wire logic                                   clock_i,
    input  wire logic                                   rstn_i,
    input  wire logic [5:0]                             sel_i,
    output logic [rit_pkg::DDC_N*rit_pkg::TB_W-1:0]     data_o
);
    import rit_pkg::*;
    logic [25:0] tick_reg;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) tick_reg <= '0;
        else tick_reg <= tick_reg + 26'h1;
    end
    always_comb begin
        for (int k = 0; k < DDC_N; k++)
            data_o[k*TB_W +: TB_W] = {k[3:0], sel_i, tick_reg};
    end
endmodule : rit_ddc_model

// file: dv/testbench.sv
// self-checking bench for rit_top: registers, streams, delays, test bus
// assumes rit_pkg, rit_ddc_model and rit_asserts compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    import rit_pkg::*;
    logic        clock_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0;
    logic        penable_i = 1'b0, pwrite_i = 1'b0, adc_valid_i = 1'b0;
    logic        pready_o, pslverr_o, rxin_cd_oe_n_o, tst_clk_o, last;
    logic        rx_valid_o, dly_valid_o, cnt_pulse_o, probe_reserved_bit_o;
    logic [7:0]  paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o;
    logic [15:0] rxin_a_i = '0, rxin_b_i = '0, rxin_c_i = '0, rxin_d_i = '0;
    logic [3:0]  sync_i = '0;
    logic [5:0]  ddc_tst_sel_o, sel;
    logic [DDC_N*TB_W-1:0] ddc_tst_data_i;
    logic [17:0] rx_data_a_o, rx_data_b_o, rx_data_c_o, rx_data_d_o, k;
    logic [17:0] dly_data_a_o, dly_data_b_o, dly_data_c_o, dly_data_d_o;
    logic [33:0] e, aq[$];
    logic [71:0] s, sq[$], dq[$];
    logic [63:0] v, hs[$];
    integer      seed = 96533;
    int          n_fail = 0, total_checks = 0, n;
    rit_top uut (.*, .rxin_c_o(), .rxin_d_o(), .tst_hi_o());
    rit_ddc_model u_ddc (.clock_i, .rstn_i, .sel_i(ddc_tst_sel_o),
        .data_o(ddc_tst_data_i));
    always #50 clock_i = ~clock_i;
    function automatic logic [71:0] pk(input logic [63:0] x);
        return {{2{x[63]}}, x[63:48], {2{x[47]}}, x[47:32],
                {2{x[31]}}, x[31:16], {2{x[15]}}, x[15:0]};
    endfunction : pk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] x);
        aq.push_back(x);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i) penable_i <= 1'b1;
        @(posedge clock_i iff pready_o);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask : apb
    // four edges per sample keep delay results apart from the next note
    task automatic smp(input logic [63:0] x);
        {rxin_d_i, rxin_c_i, rxin_b_i, rxin_a_i} <= x;
        adc_valid_i <= 1'b1;
        @(posedge clock_i) adc_valid_i <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask : smp
    task automatic report_and_stop();
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clock_i) begin
        if (pready_o && aq.size() > 0) begin
            e = aq.pop_front();
            `CHK({pslverr_o, e[33] ? prdata_o : 32'h0}, e[32:0])
        end
        if (rx_valid_o && sq.size() > 0) begin
            s = sq.pop_front();
            `CHK({rx_data_d_o, rx_data_c_o, rx_data_b_o, rx_data_a_o}, s)
        end
        if (dly_valid_o && dq.size() > 0) begin
            s = dq.pop_front();
            `CHK({dly_data_d_o, dly_data_c_o, dly_data_b_o, dly_data_a_o}, s)
        end
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        apb(0, OFF_CTRL, '0, {2'b10, RST_CTRL});
        apb(0, OFF_NOISE_MASK, '0, {18'h2_0000, RST_MASK});
        apb(0, OFF_CONST, '0, {16'h8000, RST_CONST});
        apb(0, OFF_CNT_IVAL, '0, {2'b10, RST_IVAL});
        apb(0, OFF_LFSR_A, '0, {11'h400, SEED_A});
        apb(0, 8'h40, '0, {2'b11, 32'h0});
        k = 18'($random(seed));
        apb(1, OFF_CONST, {14'h0, k}, '0);
        apb(1, OFF_CTRL, 32'h0000_000D, '0);
        @(posedge clock_i);
        repeat (8) sq.push_back({4{k}});
        repeat (12) @(posedge clock_i);
        apb(1, OFF_CTRL, 32'h0000_0002, '0);
        apb(1, OFF_DLY_OFF, 32'h3F11_0300, '0);
        apb(0, OFF_STATUS, '0, {2'b10, 32'h0});
        apb(1, OFF_DLY_SSEL, 32'h0000_7777, '0);
        apb(0, OFF_STATUS, '0, {2'b10, 32'h3F11_0300});
        for (int i = 0; i < 70; i++) begin
            v = {$random(seed), $random(seed)};
            hs.push_back(v);
            sq.push_back(pk(v));
            if (i >= 63) dq.push_back(pk({hs[i-63][63:48], hs[i-17][47:32],
                hs[i-3][31:16], v[15:0]}));
            smp(v);
        end
        apb(1, OFF_CTRL, 32'h0000_0039, '0);
        repeat (100) @(posedge clock_i) adc_valid_i <= 1'($random(seed));
        sel = 6'($random(seed));
        apb(1, OFF_TST_CFG, {10'h0, 3'd0, 4'd0, 5'd3, sel, 4'd8}, '0);
        apb(1, OFF_CTRL, 32'h0000_0040, '0);
        `CHK(rxin_cd_oe_n_o, 1'b0)
        `CHK(probe_reserved_bit_o, 1'b0)
        `CHK(ddc_tst_sel_o, sel)
        n = 0;
        last = tst_clk_o;
        repeat (40) begin
            @(posedge clock_i);
            if (tst_clk_o === 1'b1 && last === 1'b0) n++;
            last = tst_clk_o;
        end
        `CHK(n, 10)
        // counter on sync_i[0]: period interval+1, pulse width+1 cycles
        apb(1, OFF_CNT_IVAL, 32'h0000_0003, '0);
        apb(1, OFF_CNT_CFG, 32'h0000_0101, '0);
        sync_i <= 4'h1;
        @(posedge clock_i) sync_i <= 4'h0;
        repeat (8) @(posedge clock_i);
        apb(0, OFF_LFSR_A, '0, {11'h400, SEED_A});
        n = 0;
        repeat (40) @(posedge clock_i) n += int'(cnt_pulse_o);
        `CHK(n, 20)
        report_and_stop();
    end
endmodule : testbench
